// ===== hdl/mgac_map.svh
// register map, field positions, reset values and timing constants for the gate sequencer
//
// Overview of operation
// - gate opens and closes only on trigger events of the measured input.
// - with no qualifier selected, a new measurement starts once the previous finishes.
// - start needs: result processed, hold elapsed if single, preparation done, trigger.
// - averaging gate closes on first stop trigger after measuring time has elapsed.
// - single mode closes the gate at the first stop trigger, ignoring measuring time.
// - single mode holds the result for the measuring time before the next start.
// - freeze mode starts each measurement only after one operator rerun request.
// - bus trigger mode holds the start until a bus trigger arrives.
// - start qualification leaves free run; each start needs a valid qualifier edge.
// - with delay on, the delay from the qualifier edge must also expire first.
// - stop qualification keeps the gate open until the selected qualifier edge.
// - start and stop qualification together replace measuring time by the qualifier.
// - qualifier active edge is selectable rising or falling.
// - delay accepted from 200 ns to 1.6 s in 100 ns steps.
// - mantissa is event count plus one divided by gate time, up to 15 digits.
// - shown digits truncated so quantization moves the last digit at most 2.5 units.
// - start and stop qualification each set to rising, falling or off.
// - in averaging, the start qualifier acts only on the first sample.
`ifndef MGAC_MAP_SVH
`define MGAC_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define MGAC_OFS_CTRL      6'h00
`define MGAC_OFS_MTIME     6'h04
`define MGAC_OFS_DELAY     6'h08
`define MGAC_OFS_CMD       6'h0c
`define MGAC_OFS_STATUS    6'h10
`define MGAC_OFS_EVENTS    6'h14
`define MGAC_OFS_GATECYC   6'h18
`define MGAC_OFS_FREQ_LO   6'h1c
`define MGAC_OFS_FREQ_HI   6'h20
`define MGAC_OFS_DIGITS    6'h24

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define MGAC_CTRL_W        8
`define MGAC_CMD_RERUN_BIT 0
`define MGAC_SEL_OFF       2'h0
`define MGAC_SEL_RISE      2'h1
`define MGAC_SEL_FALL      2'h2
`define MGAC_CTRL_RST      8'h00
`define MGAC_MTIME_MS      200

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MGAC_CLK_NS        20
`define MGAC_CLK_HZ        50000000
`define MGAC_CLK_PS        (`MGAC_CLK_NS * 1000)
`define MGAC_MTIME_RST     (`MGAC_MTIME_MS * 1000000 / `MGAC_CLK_NS)
`define MGAC_STEP_NS       100
`define MGAC_STEP_CYC      ((`MGAC_STEP_NS + `MGAC_CLK_NS - 1) / `MGAC_CLK_NS)
`define MGAC_DLY_MIN_NS    200
`define MGAC_DLY_MAX_NS    1600000000
`define MGAC_DLY_MIN_STEPS (`MGAC_DLY_MIN_NS / `MGAC_STEP_NS)
`define MGAC_DLY_MAX_STEPS (`MGAC_DLY_MAX_NS / `MGAC_STEP_NS)
`define MGAC_QERR_PS       250
`define MGAC_LSD_TENTHS    25
`define MGAC_TENTHS        10
`define MGAC_MAX_DIGITS    15
`define MGAC_DIV_STEPS     64

`endif

// ===== hdl/mgac_pkg.sv
// types shared by the gate sequencer files
package mgac_pkg;

  typedef enum logic [2:0] {
    MGAC_S_PROC, MGAC_S_HOLD, MGAC_S_PREP, MGAC_S_ARM, MGAC_S_WAIT_TRIG, MGAC_S_GATE
  } mgac_state_t;

  typedef struct packed {
    logic       delay_en;
    logic [1:0] stop_sel;
    logic [1:0] start_sel;
    logic       bus_trig_en;
    logic       freeze;
    logic       single;
  } mgac_ctrl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
  } mgac_avs_req_t;

endpackage : mgac_pkg

// ===== hdl/mgac_step_timer.sv
// start-qualifier delay timer, one tick per delay step
`timescale 1ns/10ps
`include "mgac_map.svh"

module mgac_step_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // control
  input  wire logic        load,
  input  wire logic [23:0] steps,
  // status
  output logic             expired
);

  logic [2:0]  pre;
  logic [23:0] left;
  logic        run;
  logic        tick;

  assign tick = run && (pre == 3'(`MGAC_STEP_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre  <= 3'h0;
      left <= 24'h0;
      run  <= 1'b0;
    end else if (load) begin
      pre  <= 3'h0;
      left <= steps;
      run  <= 1'b1;
    end else if (tick) begin
      pre  <= 3'h0;
      left <= left - 24'h1;
      run  <= (left != 24'h1);
    end else if (run) begin
      pre  <= pre + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      expired <= 1'b0;
    end else if (load) begin
      expired <= 1'b0;
    end else if (tick && left == 24'h1) begin
      expired <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [27:0] ela;
  logic [23:0] lat;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ela <= 28'h0;
      lat <= 24'h0;
    end else if (load) begin
      ela <= 28'h0;
      lat <= steps;
    end else if (!expired) begin
      ela <= ela + 28'h1;
    end
  end

  property p_expiry;
    @(posedge clk) disable iff (!rst_b)
      $rose(expired) |-> (ela == 28'(lat) * 28'(`MGAC_STEP_CYC));
  endproperty
  a_expiry: assert property (p_expiry) else $error("delay expiry at wrong time");

endmodule : mgac_step_timer

// ===== hdl/mgac_top.sv
// measurement gate sequencer with register slave and result divider
`timescale 1ns/10ps
`include "mgac_map.svh"

module mgac_top #(
  parameter int unsigned MEAS_TIME_DEFAULT = `MGAC_MTIME_RST
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // register bus
  input  wire mgac_pkg::mgac_avs_req_t avs_req,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // pins
  input  wire logic                   meas_in,
  input  wire logic                   qual_in,
  // system
  input  wire logic                   bus_trigger,
  input  wire logic                   prep_ready,
  // status
  output logic                        gate_open,
  output logic                        result_strobe
);
  import mgac_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] meas_sync, qual_sync;
  logic       meas_lvl, meas_lvl_d, qual_lvl, qual_lvl_d;
  logic       trig, q_rise, q_fall;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meas_sync <= 3'h0;
      qual_sync <= 3'h0;
    end else begin
      meas_sync <= {meas_sync[1:0], meas_in};
      qual_sync <= {qual_sync[1:0], qual_in};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meas_lvl   <= 1'b0;
      meas_lvl_d <= 1'b0;
      qual_lvl   <= 1'b0;
      qual_lvl_d <= 1'b0;
    end else begin
      if (meas_sync[1] == meas_sync[2]) meas_lvl <= meas_sync[2];
      if (qual_sync[1] == qual_sync[2]) qual_lvl <= qual_sync[2];
      meas_lvl_d <= meas_lvl;
      qual_lvl_d <= qual_lvl;
    end
  end

  assign trig   = meas_lvl & ~meas_lvl_d;
  assign q_rise = qual_lvl & ~qual_lvl_d;
  assign q_fall = ~qual_lvl & qual_lvl_d;

  function automatic logic sel_edge(input logic [1:0] sel, input logic r, input logic f);
    return (sel == `MGAC_SEL_RISE) ? r : (sel == `MGAC_SEL_FALL) ? f : 1'b0;
  endfunction : sel_edge

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  mgac_ctrl_t  ctrl;
  mgac_state_t state;
  logic [31:0] mtime, events, gatecyc, next_rdata;
  logic [23:0] dsteps;
  logic [63:0] freq;
  logic [3:0]  digits;
  logic        resp, req, wr_go, dly_bad, delay_rejected, result_valid;
  logic        restart_pend, bus_pend, consume;
  logic        start_en, stop_en, qual_hit, stop_hit, dly_expired;

  assign req             = avs_req.read | avs_req.write;
  assign avs_waitrequest = req & ~resp;
  assign wr_go           = resp & avs_req.write;
  assign dly_bad         = (avs_req.writedata < 32'(`MGAC_DLY_MIN_STEPS)) ||
                           (avs_req.writedata > 32'(`MGAC_DLY_MAX_STEPS));

  always_ff @(posedge clk) begin
    if (!rst_b) resp <= 1'b0;
    else        resp <= req & ~resp;
  end

  always_comb begin
    next_rdata = 32'h0;
    unique case (avs_req.address)
      `MGAC_OFS_CTRL:    next_rdata = 32'(ctrl);
      `MGAC_OFS_MTIME:   next_rdata = mtime;
      `MGAC_OFS_DELAY:   next_rdata = 32'(dsteps);
      `MGAC_OFS_STATUS:  next_rdata = {27'h0, bus_pend, restart_pend, delay_rejected,
                                       result_valid, gate_open};
      `MGAC_OFS_EVENTS:  next_rdata = events;
      `MGAC_OFS_GATECYC: next_rdata = gatecyc;
      `MGAC_OFS_FREQ_LO: next_rdata = freq[31:0];
      `MGAC_OFS_FREQ_HI: next_rdata = freq[63:32];
      `MGAC_OFS_DIGITS:  next_rdata = 32'(digits);
      default:           next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b)           avs_readdata <= 32'h0;
    else if (req & ~resp) avs_readdata <= next_rdata;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl           <= mgac_ctrl_t'(`MGAC_CTRL_RST);
      mtime          <= MEAS_TIME_DEFAULT;
      dsteps         <= 24'(`MGAC_DLY_MIN_STEPS);
      delay_rejected <= 1'b0;
    end else if (wr_go) begin
      if (avs_req.address == `MGAC_OFS_CTRL)
        ctrl <= mgac_ctrl_t'(avs_req.writedata[`MGAC_CTRL_W-1:0]);
      if (avs_req.address == `MGAC_OFS_MTIME) mtime <= avs_req.writedata;
      if (avs_req.address == `MGAC_OFS_DELAY) begin
        delay_rejected <= dly_bad;
        if (!dly_bad) dsteps <= avs_req.writedata[23:0];
      end
    end
  end

  // set wins over the clear when both land in one cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      restart_pend <= 1'b0;
      bus_pend     <= 1'b0;
    end else begin
      restart_pend <= (wr_go && avs_req.address == `MGAC_OFS_CMD &&
                       avs_req.writedata[`MGAC_CMD_RERUN_BIT]) || (restart_pend && !consume);
      bus_pend     <= bus_trigger || (bus_pend && !consume);
    end
  end

  // ----------------------------------------------------------------
  // arming and qualifier
  // ----------------------------------------------------------------
  logic arm_ok, qual_ok, dly_load, time_ok, close;

  assign start_en = ctrl.start_sel != `MGAC_SEL_OFF;
  assign stop_en  = ctrl.stop_sel != `MGAC_SEL_OFF;
  assign dly_load = (state == MGAC_S_ARM) && start_en && !qual_hit &&
                    sel_edge(ctrl.start_sel, q_rise, q_fall);
  assign qual_ok  = !start_en || (qual_hit && (!ctrl.delay_en || dly_expired));
  assign arm_ok   = (!ctrl.freeze || restart_pend) &&
                    (!ctrl.bus_trig_en || bus_pend) && qual_ok;
  assign consume  = (state == MGAC_S_ARM) && arm_ok;

  // start qualifier only gates the gate opening; triggers inside the gate are counted unqualified
  always_ff @(posedge clk) begin
    if (!rst_b)                  qual_hit <= 1'b0;
    else if (state != MGAC_S_ARM) qual_hit <= 1'b0;
    else if (dly_load)           qual_hit <= 1'b1;
  end

  mgac_step_timer u_delay (
    .clk     (clk),
    .rst_b   (rst_b),
    .load    (dly_load),
    .steps   (dsteps),
    .expired (dly_expired)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [31:0] hold_cnt;
  logic [6:0]  dcnt;
  logic [63:0] num, quo;
  logic [31:0] rem;
  logic [32:0] next_sh;

  assign time_ok = (start_en && stop_en) || ctrl.single || (gatecyc >= mtime);
  assign close   = (state == MGAC_S_GATE) && trig && time_ok &&
                   (!stop_en || stop_hit);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= MGAC_S_PREP;
    end else begin
      unique case (state)
        MGAC_S_PROC:      if (dcnt == 7'(`MGAC_DIV_STEPS))
                            state <= ctrl.single ? MGAC_S_HOLD : MGAC_S_PREP;
        MGAC_S_HOLD:      if (hold_cnt >= mtime) state <= MGAC_S_PREP;
        MGAC_S_PREP:      if (prep_ready) state <= MGAC_S_ARM;
        MGAC_S_ARM:       if (arm_ok) state <= MGAC_S_WAIT_TRIG;
        MGAC_S_WAIT_TRIG: if (trig) state <= MGAC_S_GATE;
        MGAC_S_GATE:      if (close) state <= MGAC_S_PROC;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b)                    hold_cnt <= 32'h0;
    else if (state == MGAC_S_HOLD) hold_cnt <= hold_cnt + 32'h1;
    else                           hold_cnt <= 32'h0;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gate_open <= 1'b0;
      events    <= 32'h0;
      gatecyc   <= 32'h0;
      stop_hit  <= 1'b0;
    end else if (state == MGAC_S_WAIT_TRIG && trig) begin
      gate_open <= 1'b1;
      events    <= 32'h0;
      gatecyc   <= 32'h1;
      stop_hit  <= 1'b0;
    end else if (state == MGAC_S_GATE) begin
      gate_open <= !close;
      gatecyc   <= close ? gatecyc : gatecyc + 32'h1;
      if (trig) events <= events + 32'h1;
      if (sel_edge(ctrl.stop_sel, q_rise, q_fall)) stop_hit <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // result: restoring divider and digit truncation
  // ----------------------------------------------------------------
  function automatic logic [3:0] shown_digits(input logic [31:0] cyc);
    logic [63:0] p;
    logic [63:0] lim;
    logic [3:0]  d;
    p   = 64'h1;
    d   = 4'h1;
    lim = 64'(cyc) * 64'(`MGAC_CLK_PS * `MGAC_LSD_TENTHS);
    for (int k = 1; k <= `MGAC_MAX_DIGITS; k++) begin
      p = p * 64'ha;
      if (p * 64'(`MGAC_QERR_PS * `MGAC_TENTHS) <= lim) d = 4'(k);
    end
    return d;
  endfunction : shown_digits

  assign next_sh = {rem, num[63]};

  // frequency in hz: events plus one, times clock rate over gate cycles
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      num  <= 64'h0;
      quo  <= 64'h0;
      rem  <= 32'h0;
      dcnt <= 7'h0;
    end else if (close) begin
      num  <= 64'(events + 32'h1) * 64'(`MGAC_CLK_HZ);
      quo  <= 64'h0;
      rem  <= 32'h0;
      dcnt <= 7'h0;
    end else if (state == MGAC_S_PROC && dcnt != 7'(`MGAC_DIV_STEPS)) begin
      num  <= {num[62:0], 1'b0};
      dcnt <= dcnt + 7'h1;
      if (next_sh >= {1'b0, gatecyc}) begin
        rem <= 32'(next_sh - {1'b0, gatecyc});
        quo <= {quo[62:0], 1'b1};
      end else begin
        rem <= next_sh[31:0];
        quo <= {quo[62:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      freq          <= 64'h0;
      digits        <= 4'h0;
      result_valid  <= 1'b0;
      result_strobe <= 1'b0;
    end else begin
      result_strobe <= (state == MGAC_S_PROC) && (dcnt == 7'(`MGAC_DIV_STEPS));
      if (state == MGAC_S_PROC && dcnt == 7'(`MGAC_DIV_STEPS)) begin
        freq         <= quo;
        digits       <= shown_digits(gatecyc);
        result_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_bus_wait;
    req && avs_waitrequest;
  endsequence
  sequence s_bus_done;
    !avs_waitrequest;
  endsequence

  property p_bus_answer;
    s_bus_wait |=> s_bus_done;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("waitrequest held too long");

  property p_open_on_trig;
    $rose(gate_open) |-> $past(trig) && $past(state == MGAC_S_WAIT_TRIG);
  endproperty
  a_open_on_trig: assert property (p_open_on_trig) else $error("gate opened off trigger");

  property p_close_on_trig;
    $fell(gate_open) |-> $past(trig);
  endproperty
  a_close_on_trig: assert property (p_close_on_trig) else $error("gate closed off trigger");

  property p_free_run;
    (state == MGAC_S_ARM) && !start_en && !ctrl.freeze && !ctrl.bus_trig_en
      |=> state == MGAC_S_WAIT_TRIG;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run did not rearm");

  property p_order;
    (state == MGAC_S_PROC) |=> state inside {MGAC_S_PROC, MGAC_S_HOLD, MGAC_S_PREP};
  endproperty
  a_order: assert property (p_order) else $error("start sequence out of order");

  property p_avg_close;
    $fell(gate_open) && !ctrl.single && !(start_en && stop_en) |-> $past(gatecyc >= mtime);
  endproperty
  a_avg_close: assert property (p_avg_close) else $error("gate closed before time");

  property p_single_close;
    (state == MGAC_S_GATE) && ctrl.single && !stop_en && trig |=> !gate_open;
  endproperty
  a_single_close: assert property (p_single_close) else $error("single gate stayed open");

  property p_hold;
    (state == MGAC_S_HOLD) && (hold_cnt < mtime) |=> state == MGAC_S_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("display hold cut short");

  property p_freeze;
    (state == MGAC_S_ARM) && ctrl.freeze && !restart_pend |=> state != MGAC_S_WAIT_TRIG;
  endproperty
  a_freeze: assert property (p_freeze) else $error("started without rerun request");

  property p_bus_hold;
    (state == MGAC_S_ARM) && ctrl.bus_trig_en && !bus_pend |=> state == MGAC_S_ARM;
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("started without bus trigger");

  property p_delay;
    (state == MGAC_S_ARM) && start_en && ctrl.delay_en && !dly_expired |=> state == MGAC_S_ARM;
  endproperty
  a_delay: assert property (p_delay) else $error("started before delay expiry");

  property p_stop_qual;
    (state == MGAC_S_GATE) && stop_en && !stop_hit |=> gate_open;
  endproperty
  a_stop_qual: assert property (p_stop_qual) else $error("gate closed before stop edge");

  property p_delay_keep;
    wr_go && (avs_req.address == `MGAC_OFS_DELAY) && dly_bad |=> $stable(dsteps);
  endproperty
  a_delay_keep: assert property (p_delay_keep) else $error("bad delay was stored");

endmodule : mgac_top

// ===== bench/mgac_src_model.sv
// behavioural measured-signal and qualifier source for the gate sequencer bench
`timescale 1ns/10ps

module mgac_src_model (
  // clock
  input  wire logic       clk,
  // control
  input  wire logic       run,
  input  wire logic [7:0] half,
  input  wire logic       qual_lvl,
  // pins
  output logic            meas_in,
  output logic            qual_in
);
  logic [7:0] cnt = 8'h00;
  logic       lvl = 1'b0;

  // idle low between bursts; half >= 2 keeps both phases wide enough to be seen
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt <= 8'h00;
      lvl <= 1'b0;
    end else if (cnt == half - 8'h01) begin
      cnt <= 8'h00;
      // edges only on clock ticks, so a trigger after delay expiry lags it by a clock
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  assign meas_in = lvl;
  assign qual_in = qual_lvl;
endmodule : mgac_src_model

// ===== bench/tb_measurement_gate_arming_control.sv
// self-checking bench for the measurement gate sequencer
`timescale 1ns/10ps
`include "mgac_map.svh"

module tb_measurement_gate_arming_control;
  import mgac_pkg::*;
  logic          clk             = 1'b0;
  logic          rst_b           = 1'b0;
  mgac_avs_req_t req             = '0;
  logic          bus_trigger     = 1'b0;
  logic          prep_ready      = 1'b0;
  logic          run             = 1'b0;
  logic          qual_lvl        = 1'b0;
  logic [31:0]   rdata;
  logic [31:0]   q;
  logic          waitreq;
  logic          meas_in;
  logic          qual_in;
  logic          gate_open;
  logic          result_strobe;
  int            fail_count      = 0;
  int            samples_checked = 0;
  int            n;

  always #10 clk = ~clk;

  // short measuring time keeps the free-run loop quick
  mgac_top #(.MEAS_TIME_DEFAULT(20)) i_dut (
    .clk(clk), .rst_b(rst_b), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .meas_in(meas_in), .qual_in(qual_in),
    .bus_trigger(bus_trigger), .prep_ready(prep_ready),
    .gate_open(gate_open), .result_strobe(result_strobe));

  // period of 10 clocks, so the expected frequency is 5 MHz
  mgac_src_model i_src (
    .clk(clk), .run(run), .half(8'h05), .qual_lvl(qual_lvl),
    .meas_in(meas_in), .qual_in(qual_in));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task final_report;
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // request held until the edge that samples waitrequest low
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    req.read      <= ~wr;
    req.write     <= wr;
    req.address   <= a;
    req.writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    if (k >= 50) fail_count++;
    q = rdata;
    req <= '0;
  endtask : bus

  // sel 0: gate opens, 1: result strobe, 2: gate closes; n holds cycles waited
  task wait_for(input int sel, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel == 0 ? gate_open : sel == 1 ? result_strobe : ~gate_open) !== 1'b1
               && n < lim);
  endtask : wait_for

  // prep held low so no measurement arms before the mode is in place
  task setup(input logic [31:0] ctrl, input logic [31:0] mt, input logic go);
    run        <= 1'b0;
    prep_ready <= 1'b0;
    rst_b      <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b1, `MGAC_OFS_CTRL, ctrl);
    bus(1'b1, `MGAC_OFS_MTIME, mt);
    run <= go;
  endtask : setup

  initial begin
    #(20 * 30000);
    fail_count++;
    final_report;
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, `MGAC_OFS_CTRL, 0);
    chk(q, 32'h0);
    bus(1'b0, `MGAC_OFS_MTIME, 0);
    chk(q, 32'd20);
    bus(1'b0, `MGAC_OFS_DELAY, 0);
    chk(q, 32'd2);
    bus(1'b0, 6'h3c, 0);
    chk(q, 32'h0);
    // free run
    setup(32'h00, 32'd20, 1'b1);
    wait_for(0, 200);
    chk(n, 200);
    prep_ready <= 1'b1;
    wait_for(1, 400);
    chk(n < 400, 1);
    // gate cycles first: the next gate reopens a few cycles after the strobe
    bus(1'b0, `MGAC_OFS_GATECYC, 0);
    chk(q, 32'd20);
    bus(1'b0, `MGAC_OFS_FREQ_LO, 0);
    chk(q, 32'd5000000);
    bus(1'b0, `MGAC_OFS_FREQ_HI, 0);
    chk(q, 32'h0);
    bus(1'b0, `MGAC_OFS_DIGITS, 0);
    chk(q, 32'd3);
    wait_for(1, 400);
    chk(n < 400, 1);
    // single cycle with hold
    setup(32'h01, 32'd200, 1'b1);
    prep_ready <= 1'b1;
    wait_for(0, 400);
    wait_for(2, 400);
    chk(n <= 12, 1);
    wait_for(0, 800);
    chk(n >= 266 && n < 800, 1);
    // freeze with rerun, then bus trigger
    for (int m = 0; m < 2; m++) begin
      setup(m == 0 ? 32'h02 : 32'h04, 32'd20, 1'b1);
      prep_ready <= 1'b1;
      wait_for(0, 300);
      chk(n, 300);
      if (m == 0) bus(1'b1, `MGAC_OFS_CMD, 32'h1);
      else bus_trigger <= 1'b1;
      @(posedge clk);
      bus_trigger <= 1'b0;
      wait_for(0, 100);
      chk(n < 100, 1);
      wait_for(2, 200);
      wait_for(0, 400);
      chk(n, 400);
    end
    // rising start qualifier with a 4-step delay
    setup(32'h88, 32'd20, 1'b1);
    bus(1'b1, `MGAC_OFS_DELAY, 32'd4);
    prep_ready <= 1'b1;
    wait_for(0, 300);
    chk(n, 300);
    qual_lvl <= 1'b1;
    wait_for(0, 200);
    chk(n >= 24 && n < 200, 1);
    wait_for(2, 200);
    wait_for(0, 300);
    chk(n, 300);
    // falling start and stop: qualifier sets the gate
    setup(32'h50, 32'd5000, 1'b1);
    prep_ready <= 1'b1;
    wait_for(0, 200);
    chk(n, 200);
    qual_lvl <= 1'b0;
    wait_for(0, 100);
    chk(n < 100, 1);
    wait_for(2, 150);
    chk(n, 150);
    qual_lvl <= 1'b1;
    repeat (10) @(posedge clk);
    qual_lvl <= 1'b0;
    wait_for(2, 100);
    chk(n < 100, 1);
    // delay range limits
    bus(1'b1, `MGAC_OFS_DELAY, 32'd16000000);
    bus(1'b1, `MGAC_OFS_DELAY, 32'd16000001);
    bus(1'b1, `MGAC_OFS_DELAY, 32'd1);
    bus(1'b0, `MGAC_OFS_DELAY, 0);
    chk(q, 32'd16000000);
    bus(1'b0, `MGAC_OFS_STATUS, 0);
    chk(q[2], 1);
    final_report;
  end
endmodule : tb_measurement_gate_arming_control
